// *** cfg_host_model.sv ***
// Model of the serial interface engine that feeds the bank's register port.
// Assumes requests are taken at rising edges and answered one cycle later.
module cfg_host_model (
	// Clock.
	input  wire logic             clk,
	// Register port toward the bank.
	output clk_cfg_pkg::reg_req_s req,
	input  wire logic [7:0]       rd_data_q,
	input  wire logic             rd_valid_q
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus carries scrambled address and data, never a stale value.
	initial req = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'hA5};

	// One access: raised at a falling edge, held across the taking edge.
	task automatic access(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic v);
		@(negedge clk);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		q = rd_data_q;
		v = rd_valid_q;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// *** clk_cfg_pkg.sv ***
// Constants and carrier types of the clock generator configuration bank.
// Assumes one 100 MHz clock and an 8-bit register port fed by the serial
// interface engine on the same clock.
package clk_cfg_pkg;

	// Register port geometry.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [15:0] HOLD_GOAL_LO_OFF   = 16'h05B1;
	localparam logic [15:0] HOLD_GOAL_HI_OFF   = 16'h05B2;
	localparam logic [15:0] EXT_REF_SEL_OFF    = 16'h090E;
	localparam logic [15:0] IO_VOLT_SEL_OFF    = 16'h0943;
	localparam logic [15:0] IN_BUF_CTRL_OFF    = 16'h0949;
	localparam logic [15:0] IN_DET_GATE_OFF    = 16'h094A;
	localparam logic [15:0] IN_HYST_LO_OFF     = 16'h094E;
	localparam logic [15:0] IN_HYST_HI_THR_OFF = 16'h094F;
	localparam logic [15:0] DIV_HALF_STEP_OFF  = 16'h0A02;
	localparam logic [15:0] DIV_ROUTE_OFF      = 16'h0A03;
	localparam logic [15:0] DIV_INT_MODE_OFF   = 16'h0A04;
	localparam logic [15:0] DIV_POWER_OFF      = 16'h0A05;
	localparam logic [15:0] DIV0_AUTODIS_OFF   = 16'h0A14;
	localparam logic [15:0] DIV1_AUTODIS_OFF   = 16'h0A1A;
	localparam logic [15:0] DIV2_AUTODIS_OFF   = 16'h0A20;
	localparam logic [15:0] DIV3_AUTODIS_OFF   = 16'h0A26;

	// Field positions.
	localparam int EXT_REF_BIT     = 0;
	localparam int IO_VOLT_BIT     = 0;
	localparam int IN_ENABLE_LSB   = 0;
	localparam int IN_PULSED_LSB   = 4;
	localparam int IN_GATE_LSB     = 0;
	localparam int HYST_HI_LSB     = 0;
	localparam int THR_HIGH_LSB    = 4;
	localparam int DIV_FIELD_LSB   = 0;
	localparam int AUTODIS_BIT     = 3;

	// Reset values; the voltage select comes up at the 1.8 V setting.
	localparam logic        EXT_REF_RST   = 1'h0;
	localparam logic        IO_VOLT_RST   = 1'h0;
	localparam logic [3:0]  IN_FIELD_RST  = 4'h0;
	localparam logic [11:0] HYST_RST      = 12'h000;
	localparam logic [4:0]  DIV_FIELD_RST = 5'h00;
	localparam logic [3:0]  AUTODIS_RST   = 4'h0;
	localparam logic [15:0] HOLD_GOAL_RST = 16'h0000;
	localparam logic [7:0]  RDATA_RST     = 8'h00;
	localparam logic        VALID_RST     = 1'h0;
	localparam logic        MISS_RST      = 1'h0;

	// Per-input configuration as delivered to the input buffers.
	typedef struct packed {
		logic [3:0]  enable;
		logic [3:0]  pulsed_cmos;
		logic [3:0]  threshold_high;
		logic [3:0]  detector_gate;
		logic [11:0] hysteresis_select;
	} input_cfg_s;

	// Per-divider configuration as delivered to the output dividers.
	typedef struct packed {
		logic [4:0] half_step;
		logic [4:0] route_on;
		logic [4:0] integer_only;
		logic [4:0] power_up;
		logic [3:0] load_autodisable;
	} divider_cfg_s;

	// One register access from the serial interface engine.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

endpackage

// *** clock_config_regs.sv ***
// Configuration register bank for the reference, input and output divider
// controls of the clock generator.
// Assumes the serial interface engine runs on clk and presents at most one
// access per cycle; the serial protocol itself lives outside this module.

// Operation
// - One bit selects 1.8 V or 3.3 V.
// - Voltage select resets to 1.8 V setting.
// - Input enable bits power each buffer.
// - Bits 7:4 choose pulsed CMOS format.
// - Threshold bits choose low or standard.
// - Four bits gate inputs to detector.
// - Twelve-bit hysteresis split over two registers.
// - Five half-step bits, one per divider.
// - Route enable bits must be one; the bank resets them to zero and stores what is written.
// - Integer-mode bits choose integer-only division.
// - Power bits power dividers up or down.
// - Dividers 0-3 load auto-disable at bit 3.
// - Holdover settle goal spans two registers.
module clock_config_regs (
	// Clock and reset.
	input  wire logic                              clk,
	input  wire logic                              rst,
	// Register access from the serial interface engine.
	input  wire clk_cfg_pkg::reg_req_s             req,
	output logic        [clk_cfg_pkg::DATA_W-1:0]  rd_data_q,
	output logic                                   rd_valid_q,
	output logic                                   addr_miss_q,
	// Reference and I/O controls.
	output logic                                   external_reference_select_q,
	output logic                                   io_voltage_3v3_q,
	// Input buffer controls.
	output clk_cfg_pkg::input_cfg_s                input_cfg_q,
	// Output divider controls.
	output clk_cfg_pkg::divider_cfg_s              divider_cfg_q,
	// Holdover settle goal.
	output logic        [15:0]                     holdover_settle_goal_q
);

	// Write hit on one register offset.
	function automatic logic wr_hit(
		input clk_cfg_pkg::reg_req_s r,
		input logic [15:0]           off
	);
		wr_hit = r.wr && (r.addr == off);
	endfunction

	// Is the offset one of the mapped registers of this bank.
	function automatic logic is_mapped(input logic [15:0] a);
		case (a)
			clk_cfg_pkg::HOLD_GOAL_LO_OFF,
			clk_cfg_pkg::HOLD_GOAL_HI_OFF,
			clk_cfg_pkg::EXT_REF_SEL_OFF,
			clk_cfg_pkg::IO_VOLT_SEL_OFF,
			clk_cfg_pkg::IN_BUF_CTRL_OFF,
			clk_cfg_pkg::IN_DET_GATE_OFF,
			clk_cfg_pkg::IN_HYST_LO_OFF,
			clk_cfg_pkg::IN_HYST_HI_THR_OFF,
			clk_cfg_pkg::DIV_HALF_STEP_OFF,
			clk_cfg_pkg::DIV_ROUTE_OFF,
			clk_cfg_pkg::DIV_INT_MODE_OFF,
			clk_cfg_pkg::DIV_POWER_OFF,
			clk_cfg_pkg::DIV0_AUTODIS_OFF,
			clk_cfg_pkg::DIV1_AUTODIS_OFF,
			clk_cfg_pkg::DIV2_AUTODIS_OFF,
			clk_cfg_pkg::DIV3_AUTODIS_OFF:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	// Read value assembled from the live register state.
	logic [clk_cfg_pkg::DATA_W-1:0] rd_data_d;

	// One register per field, two for the hysteresis select; the output structs
	// are only wiring, so every field bit has exactly one process that writes it.
	logic [3:0] in_enable_q;
	logic [3:0] in_pulsed_q;
	logic [3:0] in_gate_q;
	logic [7:0] hyst_lo_q;
	logic [3:0] hyst_hi_q;
	logic [3:0] thr_high_q;
	logic [4:0] half_step_q;
	logic [4:0] route_on_q;
	logic [4:0] integer_only_q;
	logic [4:0] power_up_q;
	logic [3:0] autodis_q;

	// Input field registers gathered into the input carrier; this is pure
	// wiring, so each output bit still comes straight from a flip-flop.
	assign input_cfg_q = '{
		enable:            in_enable_q,
		pulsed_cmos:       in_pulsed_q,
		threshold_high:    thr_high_q,
		detector_gate:     in_gate_q,
		hysteresis_select: {hyst_hi_q, hyst_lo_q}
	};

	// Divider field registers gathered into the divider carrier.
	assign divider_cfg_q = '{
		half_step:        half_step_q,
		route_on:         route_on_q,
		integer_only:     integer_only_q,
		power_up:         power_up_q,
		load_autodisable: autodis_q
	};

	// External reference source select; the host must keep it set while
	// an oscillator drives the crystal pins, the bank only stores it.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			external_reference_select_q <= clk_cfg_pkg::EXT_REF_RST;
		else if (wr_hit(req, clk_cfg_pkg::EXT_REF_SEL_OFF))
			external_reference_select_q <=
				req.wdata[clk_cfg_pkg::EXT_REF_BIT];
	end

	// Digital I/O threshold select: zero is 1.8 V, one is 3.3 V. Reset
	// lands on 1.8 V so that the first writes work from either host supply.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			io_voltage_3v3_q <= clk_cfg_pkg::IO_VOLT_RST;
		else if (wr_hit(req, clk_cfg_pkg::IO_VOLT_SEL_OFF))
			io_voltage_3v3_q <=
				req.wdata[clk_cfg_pkg::IO_VOLT_BIT];
	end

	// Input buffer enables and pulsed CMOS format share one register.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			in_enable_q <= clk_cfg_pkg::IN_FIELD_RST;
			in_pulsed_q <= clk_cfg_pkg::IN_FIELD_RST;
		end
		else if (wr_hit(req, clk_cfg_pkg::IN_BUF_CTRL_OFF))
		begin
			// A zero enable bit also powers its buffer down.
			in_enable_q <=
				req.wdata[clk_cfg_pkg::IN_ENABLE_LSB +: 4];
			in_pulsed_q <=
				req.wdata[clk_cfg_pkg::IN_PULSED_LSB +: 4];
		end
	end

	// Gates each input clock into the phase detector path.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			in_gate_q <= clk_cfg_pkg::IN_FIELD_RST;
		else if (wr_hit(req, clk_cfg_pkg::IN_DET_GATE_OFF))
			in_gate_q <=
				req.wdata[clk_cfg_pkg::IN_GATE_LSB +: 4];
	end

	// Hysteresis select: low byte in one register, upper nibble shares
	// the next register with the CMOS threshold bits. Each byte lands on
	// its own write, so software sees a torn value between the two.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hyst_lo_q <= clk_cfg_pkg::HYST_RST[7:0];
		else if (wr_hit(req, clk_cfg_pkg::IN_HYST_LO_OFF))
			hyst_lo_q <= req.wdata;
	end

	// Upper hysteresis nibble and per-input CMOS threshold select.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hyst_hi_q  <= clk_cfg_pkg::HYST_RST[11:8];
			thr_high_q <= clk_cfg_pkg::IN_FIELD_RST;
		end
		else if (wr_hit(req, clk_cfg_pkg::IN_HYST_HI_THR_OFF))
		begin
			hyst_hi_q <=
				req.wdata[clk_cfg_pkg::HYST_HI_LSB +: 4];
			// Zero picks the low pulsed threshold, one the standard one.
			thr_high_q <=
				req.wdata[clk_cfg_pkg::THR_HIGH_LSB +: 4];
		end
	end

	// Half-step add, one bit per output divider.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			half_step_q <= clk_cfg_pkg::DIV_FIELD_RST;
		else if (wr_hit(req, clk_cfg_pkg::DIV_HALF_STEP_OFF))
			half_step_q <=
				req.wdata[clk_cfg_pkg::DIV_FIELD_LSB +: 5];
	end

	// Divider routing enables; a divider runs only with this bit, its
	// power bit and its clock enable elsewhere all set.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			route_on_q <= clk_cfg_pkg::DIV_FIELD_RST;
		else if (wr_hit(req, clk_cfg_pkg::DIV_ROUTE_OFF))
			route_on_q <=
				req.wdata[clk_cfg_pkg::DIV_FIELD_LSB +: 5];
	end

	// Integer-only division select. The new mode only takes hold in the
	// dividers after the host issues a soft reset; this bank does not
	// track whether that has happened.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			integer_only_q <= clk_cfg_pkg::DIV_FIELD_RST;
		else if (wr_hit(req, clk_cfg_pkg::DIV_INT_MODE_OFF))
			integer_only_q <=
				req.wdata[clk_cfg_pkg::DIV_FIELD_LSB +: 5];
	end

	// Divider power: zero powers down, one powers up.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			power_up_q <= clk_cfg_pkg::DIV_FIELD_RST;
		else if (wr_hit(req, clk_cfg_pkg::DIV_POWER_OFF))
			power_up_q <=
				req.wdata[clk_cfg_pkg::DIV_FIELD_LSB +: 5];
	end

	// Load auto-disable, bit 3 of a register of its own for dividers 0-3.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			autodis_q <= clk_cfg_pkg::AUTODIS_RST;
		else
		begin
			if (wr_hit(req, clk_cfg_pkg::DIV0_AUTODIS_OFF))
				autodis_q[0] <=
					req.wdata[clk_cfg_pkg::AUTODIS_BIT];
			if (wr_hit(req, clk_cfg_pkg::DIV1_AUTODIS_OFF))
				autodis_q[1] <=
					req.wdata[clk_cfg_pkg::AUTODIS_BIT];
			if (wr_hit(req, clk_cfg_pkg::DIV2_AUTODIS_OFF))
				autodis_q[2] <=
					req.wdata[clk_cfg_pkg::AUTODIS_BIT];
			if (wr_hit(req, clk_cfg_pkg::DIV3_AUTODIS_OFF))
				autodis_q[3] <=
					req.wdata[clk_cfg_pkg::AUTODIS_BIT];
		end
	end

	// Holdover settle goal, low byte then high byte.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			holdover_settle_goal_q <= clk_cfg_pkg::HOLD_GOAL_RST;
		else
		begin
			if (wr_hit(req, clk_cfg_pkg::HOLD_GOAL_LO_OFF))
				holdover_settle_goal_q[7:0] <= req.wdata;
			if (wr_hit(req, clk_cfg_pkg::HOLD_GOAL_HI_OFF))
				holdover_settle_goal_q[15:8] <= req.wdata;
		end
	end

	// Read mux; unused positions are padded with zeros on purpose.
	always_comb
	begin
		rd_data_d = clk_cfg_pkg::RDATA_RST;
		case (req.addr)
			clk_cfg_pkg::HOLD_GOAL_LO_OFF:
				rd_data_d = holdover_settle_goal_q[7:0];
			clk_cfg_pkg::HOLD_GOAL_HI_OFF:
				rd_data_d = holdover_settle_goal_q[15:8];
			clk_cfg_pkg::EXT_REF_SEL_OFF:
				rd_data_d[clk_cfg_pkg::EXT_REF_BIT] =
					external_reference_select_q;
			clk_cfg_pkg::IO_VOLT_SEL_OFF:
				rd_data_d[clk_cfg_pkg::IO_VOLT_BIT] =
					io_voltage_3v3_q;
			clk_cfg_pkg::IN_BUF_CTRL_OFF:
			begin
				rd_data_d[clk_cfg_pkg::IN_ENABLE_LSB +: 4] =
					input_cfg_q.enable;
				rd_data_d[clk_cfg_pkg::IN_PULSED_LSB +: 4] =
					input_cfg_q.pulsed_cmos;
			end
			clk_cfg_pkg::IN_DET_GATE_OFF:
				rd_data_d[clk_cfg_pkg::IN_GATE_LSB +: 4] =
					input_cfg_q.detector_gate;
			clk_cfg_pkg::IN_HYST_LO_OFF:
				rd_data_d = input_cfg_q.hysteresis_select[7:0];
			clk_cfg_pkg::IN_HYST_HI_THR_OFF:
			begin
				rd_data_d[clk_cfg_pkg::HYST_HI_LSB +: 4] =
					input_cfg_q.hysteresis_select[11:8];
				rd_data_d[clk_cfg_pkg::THR_HIGH_LSB +: 4] =
					input_cfg_q.threshold_high;
			end
			clk_cfg_pkg::DIV_HALF_STEP_OFF:
				rd_data_d[clk_cfg_pkg::DIV_FIELD_LSB +: 5] =
					divider_cfg_q.half_step;
			clk_cfg_pkg::DIV_ROUTE_OFF:
				rd_data_d[clk_cfg_pkg::DIV_FIELD_LSB +: 5] =
					divider_cfg_q.route_on;
			clk_cfg_pkg::DIV_INT_MODE_OFF:
				rd_data_d[clk_cfg_pkg::DIV_FIELD_LSB +: 5] =
					divider_cfg_q.integer_only;
			clk_cfg_pkg::DIV_POWER_OFF:
				rd_data_d[clk_cfg_pkg::DIV_FIELD_LSB +: 5] =
					divider_cfg_q.power_up;
			clk_cfg_pkg::DIV0_AUTODIS_OFF:
				rd_data_d[clk_cfg_pkg::AUTODIS_BIT] =
					divider_cfg_q.load_autodisable[0];
			clk_cfg_pkg::DIV1_AUTODIS_OFF:
				rd_data_d[clk_cfg_pkg::AUTODIS_BIT] =
					divider_cfg_q.load_autodisable[1];
			clk_cfg_pkg::DIV2_AUTODIS_OFF:
				rd_data_d[clk_cfg_pkg::AUTODIS_BIT] =
					divider_cfg_q.load_autodisable[2];
			clk_cfg_pkg::DIV3_AUTODIS_OFF:
				rd_data_d[clk_cfg_pkg::AUTODIS_BIT] =
					divider_cfg_q.load_autodisable[3];
			default:
				rd_data_d = clk_cfg_pkg::RDATA_RST;
		endcase
	end

	// Read valid follows each read strobe by exactly one cycle.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_valid_q <= clk_cfg_pkg::VALID_RST;
		else
			rd_valid_q <= req.rd;
	end

	// Read data one cycle after the request; it holds until the next read
	// so a slow serial shifter can pick it up at leisure. A write in the
	// same cycle lands at the same edge, so the read returns the old value.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_data_q <= clk_cfg_pkg::RDATA_RST;
		else if (req.rd)
			rd_data_q <= rd_data_d;
	end

	// Flags any access to an offset this bank does not hold, so the
	// serial engine can tell a real zero from an unmapped location.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_miss_q <= clk_cfg_pkg::MISS_RST;
		else
			addr_miss_q <= (req.rd || req.wr) && !is_mapped(req.addr);
	end

endmodule

// *** clock_config_regs_monitor.sv ***
// Checker for the configuration bank; it sees only the bank's ports.
// Assumes one clock domain and an asynchronous active high reset.
module cfg_bank_monitor (
	// Clock and reset.
	input wire logic                      clk,
	input wire logic                      rst,
	// Register port.
	input wire clk_cfg_pkg::reg_req_s     req,
	input wire logic [7:0]                rd_data_q,
	input wire logic                      rd_valid_q,
	input wire logic                      addr_miss_q,
	// Configuration outputs.
	input wire logic                      external_reference_select_q,
	input wire logic                      io_voltage_3v3_q,
	input wire clk_cfg_pkg::input_cfg_s   input_cfg_q,
	input wire clk_cfg_pkg::divider_cfg_s divider_cfg_q,
	input wire logic [15:0]               holdover_settle_goal_q
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// A write strobe aimed at one offset, and any access to soft reset.
	sequence s_wr(logic [15:0] a);
		req.wr && req.addr == a;
	endsequence
	sequence s_soft;
		(req.wr || req.rd) && req.addr == 16'h001C;
	endsequence

	// Read valid tracks reads; io, input buffer, threshold, power and divider 0 auto-disable writes land at the next edge.
	property p_rd_valid;
		rd_valid_q == $past(req.rd);
	endproperty
	property p_io;
		s_wr(clk_cfg_pkg::IO_VOLT_SEL_OFF) |=> !addr_miss_q &&
			io_voltage_3v3_q == $past(req.wdata[0]);
	endproperty
	property p_io_rst;
		$fell(rst) |-> !io_voltage_3v3_q;
	endproperty
	property p_inbuf;
		s_wr(clk_cfg_pkg::IN_BUF_CTRL_OFF) |=> $past(req.wdata) ==
			{input_cfg_q.pulsed_cmos, input_cfg_q.enable};
	endproperty
	property p_thr;
		s_wr(clk_cfg_pkg::IN_HYST_HI_THR_OFF) |=> $past(req.wdata) ==
			{input_cfg_q.threshold_high, input_cfg_q.hysteresis_select[11:8]};
	endproperty
	property p_pwr;
		s_wr(clk_cfg_pkg::DIV_POWER_OFF) |=>
			divider_cfg_q.power_up == $past(req.wdata[4:0]);
	endproperty
	property p_autodis;
		s_wr(clk_cfg_pkg::DIV0_AUTODIS_OFF) |=>
			divider_cfg_q.load_autodisable[0] == $past(req.wdata[3]);
	endproperty
	// Without a write the input, divider, holdover and io fields may not move; an access to soft reset must be flagged.
	property p_hold;
		!req.wr |=> $stable(input_cfg_q) && $stable(divider_cfg_q) &&
			$stable(holdover_settle_goal_q) && $stable(io_voltage_3v3_q);
	endproperty
	property p_miss;
		s_soft |=> addr_miss_q;
	endproperty
	// Read data stands until the next read strobe.
	property p_rd_hold;
		!req.rd |=> $stable(rd_data_q);
	endproperty

	a_rd_valid: assert property (p_rd_valid)
		else $error("read valid off");
	a_io: assert property (p_io)
		else $error("io select not stored");
	a_io_rst: assert property (p_io_rst)
		else $error("io select not 1.8 V");
	a_inbuf: assert property (p_inbuf)
		else $error("input enables wrong");
	a_thr: assert property (p_thr)
		else $error("threshold field wrong");
	a_pwr: assert property (p_pwr)
		else $error("divider power wrong");
	a_autodis: assert property (p_autodis)
		else $error("autodis wrong");
	a_hold: assert property (p_hold)
		else $error("field moved unasked");
	a_miss: assert property (p_miss)
		else $error("miss not flagged");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved");
endmodule

bind clock_config_regs cfg_bank_monitor i_mon (.clk(clk), .rst(rst),
	.req(req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
	.addr_miss_q(addr_miss_q),
	.external_reference_select_q(external_reference_select_q),
	.io_voltage_3v3_q(io_voltage_3v3_q), .input_cfg_q(input_cfg_q),
	.divider_cfg_q(divider_cfg_q),
	.holdover_settle_goal_q(holdover_settle_goal_q));

// *** tb_top.sv ***
// Self-checking bench for the configuration bank.
// Assumes the host model and the bind checker are compiled alongside.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	clk_cfg_pkg::reg_req_s     req;
	logic [7:0]                rd_data_q, q, last_q;
	logic                      rd_valid_q, addr_miss_q, ext_q, io_q, v;
	clk_cfg_pkg::input_cfg_s   in_q;
	clk_cfg_pkg::divider_cfg_s div_q;
	logic [15:0]               goal_q, a;
	logic [7:0]                sh [logic [15:0]];
	logic [15:0]               regs [16] = '{16'h05B1, 16'h05B2, 16'h090E,
		16'h0943, 16'h0949, 16'h094A, 16'h094E, 16'h094F, 16'h0A02, 16'h0A03,
		16'h0A04, 16'h0A05, 16'h0A14, 16'h0A1A, 16'h0A20, 16'h0A26};
	int                        bad_count = 0, n_checks = 0, cyc = 0;

	always #5 clk = ~clk;

	clock_config_regs i_dut (.clk(clk), .rst(rst), .req(req),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.addr_miss_q(addr_miss_q), .external_reference_select_q(ext_q),
		.io_voltage_3v3_q(io_q), .input_cfg_q(in_q), .divider_cfg_q(div_q),
		.holdover_settle_goal_q(goal_q));
	cfg_host_model i_host (.clk(clk), .req(req), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q));

	// Bits that each offset keeps; everything else must read zero.
	function automatic logic [7:0] rmask(input logic [15:0] x);
		case (x)
			16'h090E, 16'h0943: return 8'h01;
			16'h094A: return 8'h0F;
			16'h0A02, 16'h0A03, 16'h0A04, 16'h0A05: return 8'h1F;
			16'h0A14, 16'h0A1A, 16'h0A20, 16'h0A26: return 8'h08;
			default: return 8'hFF;
		endcase
	endfunction

	// Expected field outputs built from the shadow copy of the bytes.
	function automatic logic [27:0] exp_in();
		return {sh[16'h0949][3:0], sh[16'h0949][7:4], sh[16'h094F][7:4],
			sh[16'h094A][3:0], sh[16'h094F][3:0], sh[16'h094E]};
	endfunction
	function automatic logic [23:0] exp_div();
		return {sh[16'h0A02][4:0], sh[16'h0A03][4:0], sh[16'h0A04][4:0],
			sh[16'h0A05][4:0], sh[16'h0A26][3], sh[16'h0A20][3],
			sh[16'h0A1A][3], sh[16'h0A14][3]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Writes update the shadow only where an offset is mapped.
	task automatic wr(input logic [15:0] x, input logic [7:0] d);
		i_host.access(1'b1, x, d, q, v);
		if (sh.exists(x))
			sh[x] = d & rmask(x);
		// Read data from the last read must still stand after a write.
		chk({v, addr_miss_q, q}, {1'b0, !sh.exists(x), last_q});
	endtask
	task automatic rd(input logic [15:0] x);
		logic [7:0] e;
		e = sh.exists(x) ? sh[x] : 8'h00;
		i_host.access(1'b0, x, 8'h00, q, v);
		chk({v, addr_miss_q, q}, {1'b1, !sh.exists(x), e});
		last_q = e;
	endtask
	task automatic chk_outs();
		chk(in_q, exp_in());
		chk(div_q, exp_div());
		chk({ext_q, io_q, goal_q}, {sh[16'h090E][0], sh[16'h0943][0],
			sh[16'h05B2], sh[16'h05B1]});
	endtask
	task automatic reset_bank();
		rst = 1'b1;
		foreach (regs[i]) sh[regs[i]] = 8'h00;
		last_q = 8'h00;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk(io_q, 1'b0);
		chk_outs();
	endtask

	task automatic end_of_test();
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A hang is cut short; the whole run needs about 950 cycles.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	// Main sequence: reset, walls of ones and zeros, host duties, random.
	initial
	begin
		void'($urandom(55));
		reset_bank();
		foreach (regs[i]) rd(regs[i]);
		foreach (regs[i])
		begin
			wr(regs[i], 8'hFF);
			rd(regs[i]);
			chk_outs();
		end
		foreach (regs[i]) wr(regs[i], 8'h00);
		chk_outs();
		wr(16'h090E, 8'h01);
		wr(16'h0943, 8'h01);
		wr(16'h0A04, 8'h15);
		wr(16'h001C, 8'h01);
		rd(16'h001C);
		chk_outs();
		// Random traffic, now and then one past a mapped offset.
		repeat (400)
		begin
			a = regs[$urandom_range(15)] + 16'($urandom_range(7) == 0);
			if ($urandom_range(1) == 1)
				wr(a, 8'($urandom));
			else
				rd(a);
			chk_outs();
		end
		// A second reset must bring every field back, io at 1.8 V, and
		// the bank must take accesses again right after it.
		reset_bank();
		rd(16'h0943);
		wr(16'h0A05, 8'h1F);
		rd(16'h0A05);
		chk_outs();
		end_of_test();
	end
endmodule
